/* rtl/sacc_pkg.sv */
// Shared constants and types of the serial converter control block
package sacc_pkg;

    // ------------------------------------------------------------
    // Widths and clock
    // ------------------------------------------------------------
    localparam int RES_W = 12;
    localparam int MCLK_MHZ = 100;
    localparam int FIFO_DEPTH = 4;
    localparam int TIMER_W = 8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CYCLE_NS = 9000;
    localparam int ACQ_NS = 1500;
    localparam int BIT_NS = 600;
    localparam int BIT_CYC = BIT_NS * MCLK_MHZ / 1000;
    // Longest conversion, rounded down
    localparam int CONV_MAX_CYC = (CYCLE_NS - ACQ_NS) * MCLK_MHZ / 1000;
    localparam int FRAME_EDGES = 13;

    // ------------------------------------------------------------
    // Power-down pin levels and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] PD_LOW = 2'h0;
    localparam logic [1:0] PD_FLOAT = 2'h1;
    localparam logic [1:0] PD_HIGH = 2'h3;
    localparam logic [1:0] PD_RST = 2'h0;
    localparam logic [RES_W-1:0] WORD_RST = 12'h000;
    localparam logic [RES_W-1:0] TRIAL_MSB = 12'h800;
    localparam logic [3:0] MSB_IDX = 4'hb;
    localparam logic [3:0] EDGE_RST = 4'h0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONV,
        ST_PUSH,
        ST_READY
    } sacc_state_type;

endpackage

/* rtl/sacc_core.sv */
// Conversion control, result buffer and serial readout of the converter
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Result buffer
// ------------------------------------------------------------
module sacc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } sacc_fifo_regs_type;

    sacc_fifo_regs_type r;
    sacc_fifo_regs_type next_r;
    logic push;
    logic pop;

    assign in_ready_out = (r.count != FULL);
    assign out_valid_out = (r.count != '0);
    assign out_data_out = r.mem[r.rd];

    always_comb begin
        next_r = r;
        push = in_valid_in & in_ready_out;
        pop = out_valid_out & out_ready_in;
        // Pointers wrap naturally, so depth must be a power of two
        if (push) begin
            next_r.mem[r.wr] = in_data_in;
            next_r.wr = r.wr + 1'b1;
        end
        if (pop) begin
            next_r.rd = r.rd + 1'b1;
        end
        if (push && !pop) begin
            next_r.count = r.count + 1'b1;
        end else if (pop && !push) begin
            next_r.count = r.count - 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule

// ------------------------------------------------------------
// Converter control
// ------------------------------------------------------------
// Contract
// - A falling select starts a conversion.
// - Data output is high impedance while select is high.
// - Data output changes on serial clock falling edges; before the first edge it follows the end flag.
// - Each result is a 12-bit unsigned value.
// - The result goes out serially as unipolar binary.
// - A high end-of-conversion bit goes first, then result MSB first.
// - Sampling plus conversion completes within 9us on the own clock.
// - Select going low stops tracking and enters hold.
// - When conversion finishes, the sampling stage tracks again.
// - Power-down pin low puts the device in shutdown.
// - Device is operational with power-down pin high or floating.
// - Pin high enables internal reference; floating selects external.
// - On select fall output goes low, staying low until conversion ends.
// - Edges after the last bit shift zeros and leave conversion alone.
module sacc_core (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic sclk_in,
    input wire logic cs_b_in,
    input wire logic [1:0] power_down_pin_in,
    input wire logic comparator_in,
    output logic [11:0] dac_code_out,
    output logic hold_out,
    output logic ref_internal_en_out,
    output logic shutdown_out,
    output logic dout_out,
    output logic dout_oe_b_out
);

    typedef struct packed {
        sacc_pkg::sacc_state_type state;
        logic [2:0] cs_sync;
        logic cs_f;
        logic [2:0] cmp_sync;
        logic cmp_f;
        logic [1:0] pd_s0;
        logic [1:0] pd_s1;
        logic [1:0] pd_s2;
        logic [1:0] pd_f;
        logic [sacc_pkg::TIMER_W-1:0] timer;
        logic [3:0] bit_idx;
        logic [sacc_pkg::RES_W-1:0] trial;
        logic [sacc_pkg::RES_W-1:0] word;
        logic word_valid;
        logic eoc;
    } sacc_regs_type;

    typedef struct packed {
        logic [3:0] edge_cnt;
        logic dout;
    } sacc_link_type;

    localparam sacc_regs_type REGS_RST = '{
        state: sacc_pkg::ST_IDLE,
        cs_sync: 3'h7,
        cs_f: 1'b1,
        cmp_sync: 3'h0,
        cmp_f: 1'b0,
        pd_s0: sacc_pkg::PD_RST,
        pd_s1: sacc_pkg::PD_RST,
        pd_s2: sacc_pkg::PD_RST,
        pd_f: sacc_pkg::PD_RST,
        timer: '0,
        bit_idx: sacc_pkg::MSB_IDX,
        trial: sacc_pkg::WORD_RST,
        word: sacc_pkg::WORD_RST,
        word_valid: 1'b0,
        eoc: 1'b0
    };

    localparam logic [sacc_pkg::TIMER_W-1:0] BIT_LAST =
        sacc_pkg::TIMER_W'(sacc_pkg::BIT_CYC - 1);
    localparam logic [3:0] EDGE_LAST = 4'(sacc_pkg::FRAME_EDGES);
    localparam logic [3:0] RES_EDGES = 4'(sacc_pkg::RES_W);

    sacc_regs_type r;
    sacc_regs_type next_r;
    sacc_link_type link;
    sacc_link_type next_link;
    logic cs_fall;
    logic sleeping;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [sacc_pkg::RES_W-1:0] fifo_out_data;
    logic [3:0] sel;

    // ------------------------------------------------------------
    // Buffer between the converter and the readout word
    // ------------------------------------------------------------
    sacc_fifo #(
        .WIDTH(sacc_pkg::RES_W),
        .DEPTH(sacc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(fifo_in_valid),
        .in_data_in(r.trial),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(!r.word_valid)
    );

    assign fifo_in_valid = (r.state == sacc_pkg::ST_PUSH);
    assign sleeping = (r.pd_f == sacc_pkg::PD_LOW);
    assign cs_fall = r.cs_f && (r.cs_sync[1] == r.cs_sync[2])
        && !r.cs_sync[2];

    // ------------------------------------------------------------
    // Control on the own clock
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.cs_sync = {r.cs_sync[1:0], cs_b_in};
        next_r.cmp_sync = {r.cmp_sync[1:0], comparator_in};
        next_r.pd_s0 = power_down_pin_in;
        next_r.pd_s1 = r.pd_s0;
        next_r.pd_s2 = r.pd_s1;
        if (r.cs_sync[1] == r.cs_sync[2]) begin
            next_r.cs_f = r.cs_sync[2];
        end
        if (r.cmp_sync[1] == r.cmp_sync[2]) begin
            next_r.cmp_f = r.cmp_sync[2];
        end
        if (r.pd_s1 == r.pd_s2) begin
            next_r.pd_f = r.pd_s2;
        end
        // Readout word is loaded as soon as the buffer offers one
        if (fifo_out_valid && !r.word_valid) begin
            next_r.word = fifo_out_data;
            next_r.word_valid = 1'b1;
        end
        next_r.eoc = (r.state == sacc_pkg::ST_READY) && r.word_valid;
        unique case (r.state)
            sacc_pkg::ST_IDLE: begin
                if (r.cs_f) begin
                    next_r.word_valid = 1'b0;
                end
                if (cs_fall && !sleeping) begin
                    next_r.state = sacc_pkg::ST_CONV;
                    next_r.timer = '0;
                    next_r.bit_idx = sacc_pkg::MSB_IDX;
                    next_r.trial = sacc_pkg::TRIAL_MSB;
                end
            end
            sacc_pkg::ST_CONV: begin
                next_r.timer = r.timer + 1'b1;
                if (r.timer == BIT_LAST) begin
                    next_r.timer = '0;
                    // Comparator high keeps the trial bit
                    if (!r.cmp_f) begin
                        next_r.trial[r.bit_idx] = 1'b0;
                    end
                    if (r.bit_idx == '0) begin
                        next_r.state = sacc_pkg::ST_PUSH;
                    end else begin
                        next_r.bit_idx = r.bit_idx - 1'b1;
                        next_r.trial[r.bit_idx - 1'b1] = 1'b1;
                    end
                end
            end
            sacc_pkg::ST_PUSH: begin
                // Full buffer stalls the converter here
                if (fifo_in_ready) begin
                    next_r.state = sacc_pkg::ST_READY;
                end
            end
            sacc_pkg::ST_READY: begin
                if (r.cs_f) begin
                    next_r.state = sacc_pkg::ST_IDLE;
                    next_r.word_valid = 1'b0;
                end
            end
        endcase
        // Select rising or shutdown aborts whatever is running
        if (r.state != sacc_pkg::ST_IDLE && (r.cs_f || sleeping)) begin
            next_r.state = sacc_pkg::ST_IDLE;
            next_r.word_valid = 1'b0;
            next_r.eoc = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            r <= REGS_RST;
        end else begin
            r <= next_r;
        end
    end

    assign dac_code_out = r.trial;
    assign hold_out = (r.state == sacc_pkg::ST_CONV);
    assign shutdown_out = sleeping;
    assign ref_internal_en_out = (r.pd_f == sacc_pkg::PD_HIGH);

    // ------------------------------------------------------------
    // Readout on the serial clock
    // ------------------------------------------------------------
    // Word and end flag are static while the host clocks, as the
    // host waits for the end flag before the first edge
    always_comb begin
        next_link = link;
        sel = 4'(sacc_pkg::RES_W - 1) - link.edge_cnt;
        if (link.edge_cnt != EDGE_LAST) begin
            next_link.edge_cnt = link.edge_cnt + 1'b1;
        end
        next_link.dout = 1'b0;
        if (link.edge_cnt < RES_EDGES) begin
            next_link.dout = r.word[sel];
        end
    end

    always_ff @(negedge sclk_in or posedge cs_b_in) begin
        if (cs_b_in) begin
            link <= '{edge_cnt: sacc_pkg::EDGE_RST, dout: 1'b0};
        end else begin
            link <= next_link;
        end
    end

    // Before the first edge the pin shows the end flag, low while busy
    assign dout_out = (link.edge_cnt == '0) ? r.eoc : link.dout;
    assign dout_oe_b_out = cs_b_in;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [9:0] conv_cyc;

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in || !hold_out) begin
            conv_cyc <= '0;
        end else begin
            conv_cyc <= conv_cyc + 1'b1;
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence s_start;
        (r.state == sacc_pkg::ST_IDLE) && cs_fall && !sleeping;
    endsequence

    sequence s_conv_end;
        hold_out ##1 (r.state == sacc_pkg::ST_PUSH);
    endsequence

    a_conv_start: assert property (s_start |=> hold_out)
        else $error("select fall did not start conversion");
    a_hold_enter: assert property (s_start |-> !hold_out ##1 hold_out)
        else $error("hold not entered on select fall");
    a_conv_time: assert property (conv_cyc <= 10'(sacc_pkg::CONV_MAX_CYC))
        else $error("conversion ran too long");
    a_track_after: assert property (s_conv_end |-> !hold_out)
        else $error("sampling stage not tracking after conversion");
    a_eoc_rise: assert property ($rose(r.state == sacc_pkg::ST_READY)
        ##0 !r.cs_f [*3] |-> r.eoc)
        else $error("end flag missing after conversion");
    a_busy_low: assert property (hold_out |-> !r.eoc)
        else $error("end flag high during conversion");
    a_sleep_idle: assert property (sleeping |=> !hold_out)
        else $error("converting while shut down");
    a_ref_float: assert property ((r.pd_f == sacc_pkg::PD_FLOAT)
        |-> !ref_internal_en_out && !shutdown_out)
        else $error("floating pin not external reference mode");

    a_msb_first: assert property (@(negedge sclk_in) disable iff (cs_b_in)
        (link.edge_cnt == 4'h1) |-> link.dout == r.word[11])
        else $error("first bit after end flag is not MSB");
    a_trail_zero: assert property (@(negedge sclk_in) disable iff (cs_b_in)
        (link.edge_cnt == EDGE_LAST) |-> !link.dout)
        else $error("trailing bit not zero");

endmodule

`default_nettype wire

/* testbench/sacc_host_model.sv */
// Host model: drives select and serial clock, collects the data stream
`timescale 1ns/1ns
`default_nettype none

module sacc_host_model (
    input wire logic go_in,
    input wire logic abort_in,
    input wire logic dout_in,
    input wire logic dout_oe_b_in,
    output logic cs_b_out,
    output logic sclk_out,
    output logic [15:0] rise_bits_out,
    output logic [15:0] fall_bits_out,
    output logic eoc_out,
    output logic done_out
);
    // ------------------------------------------------------------
    // Frame sequence
    // ------------------------------------------------------------
    initial begin
        cs_b_out = 1'b1;
        sclk_out = 1'b0;
        rise_bits_out = 16'h0000;
        fall_bits_out = 16'h0000;
        eoc_out = 1'b0;
        done_out = 1'b0;
    end

    always @(posedge go_in) begin
        integer n;
        n = 0;
        done_out = 1'b0;
        eoc_out = 1'b0;
        cs_b_out = 1'b0;
        // Clock stands still until the end flag, 9 us at most
        while (n < 900 && !eoc_out && !(abort_in && n == 100)) begin
            #10;
            n++;
            eoc_out = (dout_oe_b_in === 1'b0) && (dout_in === 1'b1);
        end
        if (eoc_out) begin
            // Three spare edges beyond the 13 needed
            // Period fixed by the bench; readout has no lower bound on it
            for (int i = 0; i < 16; i++) begin
                #40 sclk_out = 1'b1;
                rise_bits_out = {rise_bits_out[14:0], dout_in};
                #39 fall_bits_out = {fall_bits_out[14:0], dout_in};
                #1 sclk_out = 1'b0;
            end
            #40;
        end
        cs_b_out = 1'b1;
        // Acquisition gap before the next frame may start
        #1500 done_out = 1'b1;
    end
endmodule

`default_nettype wire

/* testbench/serial_adc_conversion_control_bench.sv */
// Self-checking bench of the converter control block
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin \
    compares++; \
    if ((a) !== (b)) begin \
        n_fail++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
end

module serial_adc_conversion_control_bench;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic go = 1'b0;
    logic abort = 1'b0;
    logic [1:0] pd = sacc_pkg::PD_HIGH;
    logic [11:0] ana = 12'h000;
    logic cs_b, sclk, eoc, done, hold, ref_en, power_down_pin, dout, dout_oe_b;
    logic comparator;
    logic [11:0] dac_code;
    logic [15:0] rise_bits, fall_bits;
    int n_fail = 0;
    int compares = 0;

    // Ideal comparator stands in for the analog front end
    assign comparator = (ana >= dac_code);
    always #5 mclk = ~mclk;

    sacc_core sacc_core_inst (
        .mclk_in(mclk), .rst_b_in(rst_b), .sclk_in(sclk), .cs_b_in(cs_b),
        .power_down_pin_in(pd), .comparator_in(comparator),
        .dac_code_out(dac_code), .hold_out(hold),
        .ref_internal_en_out(ref_en), .shutdown_out(power_down_pin),
        .dout_out(dout), .dout_oe_b_out(dout_oe_b)
    );

    sacc_host_model sacc_host_model_inst (
        .go_in(go), .abort_in(abort), .dout_in(dout),
        .dout_oe_b_in(dout_oe_b), .cs_b_out(cs_b), .sclk_out(sclk),
        .rise_bits_out(rise_bits), .fall_bits_out(fall_bits),
        .eoc_out(eoc), .done_out(done)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic test_done;
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic start_frame;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        // Sample well inside the conversion, clear of the abort point
        repeat (79) @(posedge mclk);
    endtask

    task automatic wait_done;
        int k;
        k = 0;
        while (done !== 1'b1 && k < 3000) begin
            @(posedge mclk);
            k++;
        end
        if (k == 3000) begin
            n_fail++;
            test_done();
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        `CHK(hold, 1'b0)
        `CHK(dac_code, sacc_pkg::WORD_RST)
        `CHK(power_down_pin, 1'b1)
        `CHK(ref_en, 1'b0)
        `CHK(dout_oe_b, 1'b1)
    endtask

    task automatic t_mode(input logic [1:0] code, input logic s,
                          input logic r);
        pd <= code;
        repeat (10) @(posedge mclk);
        `CHK(power_down_pin, s)
        `CHK(ref_en, r)
    endtask

    task automatic t_convert(input logic [11:0] v, input logic [1:0] code);
        ana <= v;
        pd <= code;
        repeat (10) @(posedge mclk);
        start_frame();
        `CHK(hold, 1'b1)
        `CHK(dout_oe_b, 1'b0)
        `CHK(dout, 1'b0)
        wait_done();
        `CHK(eoc, 1'b1)
        `CHK(rise_bits, {1'b1, v, 3'h0})
        `CHK(fall_bits, {1'b1, v, 3'h0})
        `CHK(hold, 1'b0)
        `CHK(dout_oe_b, 1'b1)
    endtask

    task automatic t_shutdown;
        pd <= sacc_pkg::PD_LOW;
        repeat (10) @(posedge mclk);
        start_frame();
        `CHK(hold, 1'b0)
        wait_done();
        `CHK(eoc, 1'b0)
    endtask

    task automatic t_abort;
        abort <= 1'b1;
        ana <= 12'h7ff;
        pd <= sacc_pkg::PD_HIGH;
        repeat (10) @(posedge mclk);
        start_frame();
        `CHK(hold, 1'b1)
        wait_done();
        `CHK(eoc, 1'b0)
        `CHK(hold, 1'b0)
        abort <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        t_reset();
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (10) @(posedge mclk);
        t_mode(sacc_pkg::PD_LOW, 1'b1, 1'b0);
        t_mode(sacc_pkg::PD_FLOAT, 1'b0, 1'b0);
        t_mode(sacc_pkg::PD_HIGH, 1'b0, 1'b1);
        t_convert(12'h000, sacc_pkg::PD_HIGH);
        t_convert(12'hfff, sacc_pkg::PD_HIGH);
        t_convert(12'ha5c, sacc_pkg::PD_FLOAT);
        t_shutdown();
        t_convert(12'h001, sacc_pkg::PD_HIGH);
        t_abort();
        t_convert(12'h3c6, sacc_pkg::PD_HIGH);
        test_done();
    end
endmodule

`undef CHK
`default_nettype wire
